// ==== core/rsq_consts.svh ====
// constants for the reset sequencer; the rules below also cover the lock-change interrupt logic
// What this block does
// (R1) five events start reset: pin low, power-on, illegal access, watchdog, oscillator fail
// (R2) pin driven low 516 cycles after the event, 517 with sync latency
// (R3) reset entry taken on a clock edge; leaving reset needs the running clock
// (R4) after release wait 256 more cycles, then sample the pin
// (R5) vector: pin low gives por; else osc fail, else watchdog, else por
// (R6) internal reset held for 773 cycles, longer while pin held low
// (R7) oscillator loss or low frequency raises oscillator monitor reset
// (R8) watchdog timeout starts reset and marks watchdog pending
// (R9) power-on detector raises power-on reset
// (R10) lock-change flag set on every toggle of lock status not caused by a trim write
// (R11) lock-change flag cleared only by software writing one
// (R12) lock interrupt needs enable bit and processor mask bit clear
// (R13) board must let released pin rise within 256 cycles
// (R14) illegal-access flag set on access, cleared by writing one only
// (R15) trim register writes clear lock status without setting lock-change flag
// (R16) sampled pin passes a synchroniser before vector choice
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH
`define RSQ_DRIVE_CYC   10'h0204
`define RSQ_WAIT_CYC    10'h0100
`define RSQ_TOTAL_CYC   10'h0300
`define RSQ_CNT_W       10
`define RSQ_VEC_POR     2'h0
`define RSQ_VEC_OSC     2'h1
`define RSQ_VEC_WDG     2'h2
`endif

// ==== core/rsq_pkg.sv ====
// types for the reset sequencer
package rsq_pkg;
  typedef enum logic [1:0] {
    RSQ_IDLE  = 2'b00,
    RSQ_DRIVE = 2'b01,
    RSQ_WAIT  = 2'b10,
    RSQ_HOLD  = 2'b11
  } rsq_state_t;

  typedef struct packed {
    logic pin_low;
    logic por;
    logic illegal;
    logic wdg;
    logic osc_fail;
  } rsq_src_t;

  typedef struct packed {
    rsq_state_t  st;
    logic [9:0]  cnt;
    logic        osc_pend;
    logic        wdg_pend;
    logic [1:0]  vec;
    logic        pin_oe;
    logic        core_rst;
    logic        ila_flag;
    logic        lock_st;
    logic        lock_prev;
    logic        lock_flag;
    logic        irq;
  } rsq_state_reg_t;
endpackage

// ==== core/rsq_sync3.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rsq_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic [2:0] sh_q;
  logic       q_q;
  // stage 0 feeds only stage 1; output changes when stages 1 and 2 agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh_q <= {3{RST_VAL}};
      q_q  <= RST_VAL;
    end
    else
    begin
      sh_q <= {sh_q[1:0], d_i};
      if (sh_q[1] == sh_q[2])
        q_q <= sh_q[2];
    end
  end
  assign q_o = q_q;
endmodule
`default_nettype wire

// ==== core/rsq_top.sv ====
// reset sequencer with vector choice and lock-change interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rsq_consts.svh"
module rsq_top (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire rsq_pkg::rsq_src_t src_i,
  input  wire logic            pin_i,
  output logic                 pin_o,
  output logic                 pin_oe_o,
  output logic                 core_rst_o,
  output logic [1:0]           vec_o,
  input  wire logic            lock_det_i,
  input  wire logic            trim_wr_i,
  input  wire logic            lock_flag_clr_i,
  input  wire logic            ila_flag_clr_i,
  input  wire logic            lock_irq_enable_i,
  input  wire logic            ccr_imask_i,
  output logic                 freq_lock_status_o,
  output logic                 lock_change_flag_o,
  output logic                 illegal_access_flag_o,
  output logic                 lock_irq_o
);
  import rsq_pkg::*;

  rsq_state_reg_t s_q;
  rsq_state_reg_t s_d;
  logic           pin_s;
  logic           any_src;

  // the shared counter runs through drive and wait phases without wrapping
  if (`RSQ_DRIVE_CYC + `RSQ_WAIT_CYC >= (1 << `RSQ_CNT_W))
  begin : g_cnt_chk
    $error("sequence counter too narrow");
  end

  // pin level filtered before anything samples it
  rsq_sync3 #(.RST_VAL(1'b1)) u_pin_sync ( // (R16)
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_i),
    .q_o   (pin_s)
  );

  // any event starts the sequence; pin event taken after filtering
  assign any_src = src_i.por | src_i.illegal | src_i.wdg | src_i.osc_fail | ~pin_s; // (R1) (R7) (R9)

  // next state of sequencer and flags
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      RSQ_IDLE:
      begin
        if (any_src) // (R1)
        begin
          s_d.st       = RSQ_DRIVE;
          s_d.cnt      = '0;
          s_d.pin_oe   = 1'b1; // (R2)
          s_d.core_rst = 1'b1; // (R6)
        end
      end
      RSQ_DRIVE:
      begin
        s_d.cnt = s_q.cnt + 10'h0001;
        if (s_q.cnt == `RSQ_DRIVE_CYC - 10'h0001) // (R2)
        begin
          s_d.pin_oe = 1'b0;
          s_d.st     = RSQ_WAIT;
        end
      end
      RSQ_WAIT:
      begin
        s_d.cnt = s_q.cnt + 10'h0001;
        if (s_q.cnt == `RSQ_DRIVE_CYC + `RSQ_WAIT_CYC - 10'h0001) // (R4)
        begin
          s_d.st = RSQ_HOLD;
          if (!pin_s) // (R5)
            s_d.vec = `RSQ_VEC_POR;
          else if (s_q.osc_pend)
            s_d.vec = `RSQ_VEC_OSC;
          else if (s_q.wdg_pend)
            s_d.vec = `RSQ_VEC_WDG;
          else
            s_d.vec = `RSQ_VEC_POR;
        end
      end
      RSQ_HOLD:
      begin
        // external low drive stretches the internal reset
        if (pin_s) // (R6)
        begin
          s_d.core_rst = 1'b0;
          s_d.osc_pend = 1'b0;
          s_d.wdg_pend = 1'b0;
          s_d.st       = RSQ_IDLE;
        end
      end
      default:
        s_d.st = RSQ_IDLE;
    endcase
    // new non-pin events in the wait or hold phase restart the drive phase
    if (s_q.st != RSQ_IDLE && s_q.st != RSQ_DRIVE && (src_i.por | src_i.illegal | src_i.wdg | src_i.osc_fail)) // (R3)
    begin
      s_d.st       = RSQ_DRIVE;
      s_d.cnt      = '0;
      s_d.pin_oe   = 1'b1;
      s_d.core_rst = 1'b1;
    end
    if (src_i.osc_fail)
      s_d.osc_pend = 1'b1; // (R7)
    if (src_i.wdg)
      s_d.wdg_pend = 1'b1; // (R8)
    // illegal-access flag: set beats clear
    if (ila_flag_clr_i)
      s_d.ila_flag = 1'b0; // (R14)
    if (src_i.illegal)
      s_d.ila_flag = 1'b1; // (R14)
    // lock status: trim write forces unlocked, edge detect excludes it
    s_d.lock_st = trim_wr_i ? 1'b0 : lock_det_i; // (R15)
    s_d.lock_prev = s_d.lock_st;
    if (lock_flag_clr_i)
      s_d.lock_flag = 1'b0; // (R11)
    if (!trim_wr_i && (lock_det_i != s_q.lock_prev))
      s_d.lock_flag = 1'b1; // (R10)
    s_d.irq = s_d.lock_flag & lock_irq_enable_i & ~ccr_imask_i; // (R12)
  end

  // state register; reset clears flags and pendings and starts the sequencer in the drive phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q          <= '0;
      s_q.st       <= RSQ_DRIVE;
      s_q.pin_oe   <= 1'b1;
      s_q.core_rst <= 1'b1;
      s_q.vec      <= `RSQ_VEC_POR;
    end
    else
      s_q <= s_d;
  end

  assign pin_o                 = 1'b0;
  assign pin_oe_o              = s_q.pin_oe;
  assign core_rst_o            = s_q.core_rst;
  assign vec_o                 = s_q.vec;
  assign freq_lock_status_o    = s_q.lock_st;
  assign lock_change_flag_o    = s_q.lock_flag;
  assign illegal_access_flag_o = s_q.ila_flag;
  assign lock_irq_o            = s_q.irq;

  // drive phase length checked with a helper counter
  logic [10:0] oe_run_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      oe_run_q <= '0;
    else if (s_q.pin_oe && s_q.cnt != 10'h0000)
      oe_run_q <= oe_run_q + 11'h001;
    else
      oe_run_q <= '0;
  end

  AST_DRIVE_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // (R2)
    oe_run_q <= `RSQ_DRIVE_CYC) else $error("reset pin drive too long");
  AST_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // (R2)
    (s_q.st == RSQ_DRIVE && s_q.cnt == `RSQ_DRIVE_CYC - 10'h0001) |=> !pin_oe_o) else $error("pin not released");
  AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i) // (R3)
    ((s_q.st == RSQ_WAIT || s_q.st == RSQ_HOLD) && (src_i.por || src_i.illegal || src_i.wdg || src_i.osc_fail))
    |=> (s_q.st == RSQ_DRIVE && s_q.cnt == '0 && pin_oe_o)) else $error("late event did not restart drive");
  AST_START: assert property (@(posedge clk_i) disable iff (rst_i) // (R1)
    (s_q.st == RSQ_IDLE && any_src) |=> (pin_oe_o && core_rst_o)) else $error("reset not started");
  AST_CORE_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // (R6)
    (s_q.st != RSQ_IDLE) |-> core_rst_o) else $error("core reset dropped early");
  AST_HOLD_PIN: assert property (@(posedge clk_i) disable iff (rst_i) // (R6)
    (s_q.st == RSQ_HOLD && !pin_s) |=> core_rst_o) else $error("core reset ended while pin low");
  // vector choice at the sampling point
  AST_VEC_OSC: assert property (@(posedge clk_i) disable iff (rst_i) // (R5)
    (s_q.st == RSQ_WAIT && s_q.cnt == `RSQ_DRIVE_CYC + `RSQ_WAIT_CYC - 10'h0001 && pin_s && s_q.osc_pend)
    |=> vec_o == `RSQ_VEC_OSC) else $error("oscillator vector wrong");
  AST_VEC_WDG: assert property (@(posedge clk_i) disable iff (rst_i) // (R5)
    (s_q.st == RSQ_WAIT && s_q.cnt == `RSQ_DRIVE_CYC + `RSQ_WAIT_CYC - 10'h0001 && pin_s && !s_q.osc_pend &&
     s_q.wdg_pend) |=> vec_o == `RSQ_VEC_WDG) else $error("watchdog vector wrong");
  AST_VEC_PIN: assert property (@(posedge clk_i) disable iff (rst_i) // (R5)
    (s_q.st == RSQ_WAIT && s_q.cnt == `RSQ_DRIVE_CYC + `RSQ_WAIT_CYC - 10'h0001 && !pin_s)
    |=> vec_o == `RSQ_VEC_POR) else $error("pin-low vector wrong");
  // sampling point sits a full wait phase after release
  AST_WAIT_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // (R4)
    (s_q.st == RSQ_HOLD) |-> s_q.cnt == `RSQ_DRIVE_CYC + `RSQ_WAIT_CYC) else $error("pin sampled at wrong time");
  AST_SEQ_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // (R6)
    (s_q.st == RSQ_HOLD) |-> s_q.cnt >= `RSQ_TOTAL_CYC) else $error("sequence shorter than minimum");
  AST_WDG_PEND: assert property (@(posedge clk_i) disable iff (rst_i) // (R8)
    src_i.wdg |=> s_q.wdg_pend) else $error("watchdog pending not marked");
  AST_LOCK_SET: assert property (@(posedge clk_i) disable iff (rst_i) // (R10)
    (!trim_wr_i && lock_det_i != s_q.lock_prev) |=> lock_change_flag_o) else $error("lock flag not set");
  AST_LOCK_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // (R11)
    (!lock_flag_clr_i && lock_change_flag_o) |=> lock_change_flag_o) else $error("lock flag lost");
  AST_TRIM: assert property (@(posedge clk_i) disable iff (rst_i) // (R15)
    trim_wr_i |=> !freq_lock_status_o) else $error("trim write left lock set");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i) // (R12)
    lock_irq_o |-> $past(lock_irq_enable_i) && !$past(ccr_imask_i)) else $error("irq without enable");
  AST_ILA: assert property (@(posedge clk_i) disable iff (rst_i) // (R14)
    src_i.illegal |=> illegal_access_flag_o) else $error("illegal flag not set");
  // flag, pending and interrupt checks
  AST_ILA_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // (R14)
    (!ila_flag_clr_i && illegal_access_flag_o) |=> illegal_access_flag_o) else $error("illegal flag lost");
  AST_TRIM_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // (R15)
    (trim_wr_i && !lock_change_flag_o) |=> !lock_change_flag_o) else $error("trim write set lock flag");
  AST_OSC_PEND: assert property (@(posedge clk_i) disable iff (rst_i) // (R7)
    src_i.osc_fail |=> s_q.osc_pend) else $error("oscillator pending not marked");
  AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i) // (R12)
    (lock_change_flag_o && !lock_flag_clr_i && lock_irq_enable_i && !ccr_imask_i) |=> lock_irq_o)
    else $error("enabled irq missing");

  COV_SEQ: cover property (@(posedge clk_i) disable iff (rst_i) s_q.st == RSQ_HOLD ##1 s_q.st == RSQ_IDLE);
  COV_WDG: cover property (@(posedge clk_i) disable iff (rst_i) s_q.st == RSQ_HOLD && vec_o == `RSQ_VEC_WDG);
  COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) lock_irq_o);
  // coverage of the remaining vector and stretched reset
  COV_OSC: cover property (@(posedge clk_i) disable iff (rst_i) s_q.st == RSQ_HOLD && vec_o == `RSQ_VEC_OSC);
  COV_EXT: cover property (@(posedge clk_i) disable iff (rst_i) s_q.st == RSQ_HOLD && !pin_s);
endmodule
`default_nettype wire

// ==== test/rsq_board_model.sv ====
// board side of the reset pin: pull-up plus an optional external hold
`timescale 1ns/1ps
`default_nettype none
module rsq_board_model (
  input  wire logic oe_i,
  input  wire logic drv_i,
  input  wire logic hold_low_i,
  output logic      pin_o
);
  // strong pull-up, so the released pin is high well inside 256 cycles
  assign pin_o = (oe_i && !drv_i) ? 1'b0 : !hold_low_i;
endmodule
`default_nettype wire

// ==== test/test_rsq_top.sv ====
// self-checking bench for the reset sequencer and lock-change flag
`timescale 1ns/1ps
`default_nettype none
`include "rsq_consts.svh"
module test_rsq_top;
  import rsq_pkg::*;
  logic clk_i = 0, rst_i = 1, pin_i, pin_o, pin_oe_o, core_rst_o, hold_low = 0, meas = 0, rst_prev = 0;
  logic lock_det_i = 0, lock_flag_clr_i = 0, ila_flag_clr_i = 0, lock_irq_enable_i = 0, ccr_imask_i = 0;
  logic trim_wr_i = 0;
  logic freq_lock_status_o, lock_change_flag_o, illegal_access_flag_o, lock_irq_o;
  logic [1:0] vec_o;
  rsq_src_t src_i = '0;
  logic [1:0] exp_q[$];
  int miscompares = 0, n_tests = 0, n_done = 0, oe_cnt = 0;

  rsq_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .src_i(src_i), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .core_rst_o(core_rst_o), .vec_o(vec_o), .lock_det_i(lock_det_i),
    .trim_wr_i(trim_wr_i), .lock_flag_clr_i(lock_flag_clr_i), .ila_flag_clr_i(ila_flag_clr_i),
    .lock_irq_enable_i(lock_irq_enable_i), .ccr_imask_i(ccr_imask_i),
    .freq_lock_status_o(freq_lock_status_o), .lock_change_flag_o(lock_change_flag_o),
    .illegal_access_flag_o(illegal_access_flag_o), .lock_irq_o(lock_irq_o));
  rsq_board_model board_u (.oe_i(pin_oe_o), .drv_i(pin_o), .hold_low_i(hold_low), .pin_o(pin_i));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watcher: drive length per event, vector taken as the internal reset drops
  always @(posedge clk_i)
  begin
    rst_prev <= core_rst_o;
    if (rst_i || pin_oe_o !== 1'b1)
      oe_cnt <= 0;
    else
      oe_cnt <= oe_cnt + 1;
    if (meas && pin_oe_o === 1'b0 && oe_cnt != 0)
    begin
      check(10'(oe_cnt == int'(`RSQ_DRIVE_CYC) || oe_cnt == int'(`RSQ_DRIVE_CYC) + 1), 10'h001, "drive length");
      meas <= 0;
    end
    if (!rst_i && rst_prev === 1'b1 && core_rst_o === 1'b0)
    begin
      check(10'(vec_o), 10'(exp_q.pop_front()), "vector");
      n_done <= n_done + 1;
    end
  end

  // bounded wait for the next completed sequence
  task automatic wait_done(input int n0);
    for (int i = 0; i < 3000 && n_done == n0; i++)
      @(negedge clk_i);
    if (n_done == n0)
    begin
      miscompares++;
      $display("wrong value at %0t: sequence never ended", $time);
      stop_test();
    end
  endtask

  // one reset event, optional external hold of the pin beyond the sequence
  task automatic run_seq(input rsq_src_t s, input int hold, input logic [1:0] ev);
    int n0;
    n0 = n_done;
    exp_q.push_back(ev);
    repeat ($urandom % 16 + 2) @(negedge clk_i);
    src_i = s;
    hold_low = (hold > 0);
    meas = 1;
    @(negedge clk_i);
    src_i = '0;
    // a pin-only reset shows up after the input filter
    if (s == '0)
      repeat (5) @(negedge clk_i);
    check(10'(core_rst_o), 10'h001, "reset entry");
    check(10'(pin_i), 10'h000, "pin pulled low");
    if (hold > 0)
    begin
      repeat (hold) @(negedge clk_i);
      check(10'(core_rst_o), 10'h001, "reset held by pin");
      hold_low = 0;
    end
    wait_done(n0);
    $display("sequence done, vector %0d", ev);
  endtask

  // main sequence
  initial
  begin
    void'($urandom(12));
    exp_q.push_back(2'h0);
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    wait_done(0);
    run_seq(5'h08, 0, `RSQ_VEC_POR);
    run_seq(5'h04, 0, `RSQ_VEC_POR);
    check(10'(illegal_access_flag_o), 10'h001, "illegal flag");
    ila_flag_clr_i = 1;
    @(negedge clk_i);
    ila_flag_clr_i = 0;
    @(negedge clk_i);
    check(10'(illegal_access_flag_o), 10'h000, "illegal flag clear");
    run_seq(5'h01, 0, `RSQ_VEC_OSC);
    run_seq(5'h02, 0, `RSQ_VEC_WDG);
    run_seq(5'h03, 0, `RSQ_VEC_OSC);
    run_seq(5'h01, 800 + $urandom % 100, `RSQ_VEC_POR);
    run_seq('0, 800 + $urandom % 100, `RSQ_VEC_POR);
    // second event in the wait phase restarts the drive phase
    exp_q.push_back(`RSQ_VEC_WDG);
    src_i = 5'h08;
    @(negedge clk_i);
    src_i = '0;
    repeat (600) @(negedge clk_i);
    src_i = 5'h02;
    @(negedge clk_i);
    src_i = '0;
    check(10'(pin_oe_o), 10'h001, "drive restarted");
    wait_done(n_done);
    $display("restart test done");
    lock_irq_enable_i = 1;
    for (int k = 0; k < 2; k++)
    begin
      lock_det_i = !lock_det_i;
      repeat (5) @(negedge clk_i);
      check(10'(lock_change_flag_o), 10'h001, "lock flag");
      check(10'(lock_irq_o), 10'h001, "lock irq");
      ccr_imask_i = 1;
      repeat (3) @(negedge clk_i);
      check(10'(lock_irq_o), 10'h000, "lock irq masked");
      ccr_imask_i = 0;
      lock_flag_clr_i = 1;
      @(negedge clk_i);
      lock_flag_clr_i = 0;
      repeat (3) @(negedge clk_i);
      check(10'(lock_change_flag_o), 10'h000, "lock flag clear");
      check(10'(lock_irq_o), 10'h000, "lock irq cleared");
      $display("lock toggle %0d done", k);
    end
    // trim write clears lock status without raising the flag
    lock_irq_enable_i = 0;
    lock_det_i = 1;
    repeat (3) @(negedge clk_i);
    check(10'(freq_lock_status_o), 10'h001, "lock status");
    check(10'(lock_change_flag_o), 10'h001, "lock flag set");
    check(10'(lock_irq_o), 10'h000, "irq disabled");
    lock_flag_clr_i = 1;
    @(negedge clk_i);
    lock_flag_clr_i = 0;
    trim_wr_i = 1;
    @(negedge clk_i);
    trim_wr_i = 0;
    check(10'(freq_lock_status_o), 10'h000, "trim clears status");
    check(10'(lock_change_flag_o), 10'h000, "trim leaves flag");
    repeat (2) @(negedge clk_i);
    check(10'(lock_change_flag_o), 10'h001, "relock flag");
    $display("trim test done");
    // reset in mid-run: sequence starts over in the drive phase
    exp_q.push_back(`RSQ_VEC_POR);
    rst_i = 1;
    meas = 1;
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    check(10'(core_rst_o), 10'h001, "core reset during reset");
    check(10'(pin_i), 10'h000, "pin low during reset");
    wait_done(n_done);
    $display("mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
